// ===== pca8_params.svh
// constants of the 8-bit pwm counter array module
`ifndef PCA8_PARAMS_SVH
`define PCA8_PARAMS_SVH
`define PCA8_DIV_W 2
`define PCA8_DIV_LAST 2'h3
`define PCA8_DIV_RST 2'h0
`define PCA8_CNT_MAX 8'hff
`define PCA8_CNT_RST 8'h00
`define PCA8_CNT_ONE 8'h01
`define PCA8_CMP_RST 8'h00
`define PCA8_CLS_8BIT 2'h0
`define PCA8_PERIOD 9'h100
`define PCA8_PER_RST 9'h000
`define PCA8_PER_ONE 9'h001
`endif

// ===== pca8_pkg.sv
// types of the 8-bit pwm counter array module
package pca8_pkg;
  typedef logic [7:0] pca8_byte_t;
  typedef enum logic [1:0]
  {
    PCA8_CLS_8 = 2'h0,
    PCA8_CLS_9 = 2'h1,
    PCA8_CLS_10 = 2'h2,
    PCA8_CLS_11 = 2'h3
  } pca8_cls_e;
endpackage : pca8_pkg

// ===== pca8_pwm.sv
// one counter array module in 8-bit pwm mode
`timescale 1ns/10ps
`include "pca8_params.svh"

// Notes on behaviour
// (RL1) match on counter low byte sets output
// (RL2) counter low byte overflow clears output
// (RL3) overflow reloads compare low from high
// (RL4) mode needs enable, select, length 00b
// (RL5) match sets match flag when enabled
// (RL6) overflow flag every 256 counter clocks
// (RL7) compare low write clears comparator enable
// (RL8) compare high write sets comparator enable
// (RL9) high time is 256 minus compare high
// (RL10) enable cleared gives no set, 0% duty
// (RL11) software writes low byte before high
// (RL12) flags stay set until software clears
module pca8_pwm
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic counter_run,
  input wire logic cpl_wr,
  input wire logic cph_wr,
  input wire pca8_pkg::pca8_byte_t wr_data,
  input wire logic pwm_select,
  input wire logic match_flag_enable,
  input wire pca8_pkg::pca8_cls_e cycle_length_select,
  input wire logic match_flag_clr,
  input wire logic ovf_flag_clr,
  output logic comparator_enable,
  output pca8_pkg::pca8_byte_t compare_low_byte,
  output pca8_pkg::pca8_byte_t compare_high_byte,
  output pca8_pkg::pca8_byte_t counter_low_byte,
  output logic module_output_pin,
  output logic module_match_flag,
  output logic cycle_overflow_flag
);
  import pca8_pkg::*;

  logic [`PCA8_DIV_W-1:0] div_r;
  logic [`PCA8_DIV_W-1:0] div_nxt;
  pca8_byte_t cnt_r;
  pca8_byte_t cnt_nxt;
  pca8_byte_t cpl_r;
  pca8_byte_t cpl_nxt;
  pca8_byte_t cph_r;
  pca8_byte_t cph_nxt;
  logic ecom_r;
  logic ecom_nxt;
  logic pin_r;
  logic pin_nxt;
  logic ccf_r;
  logic ccf_nxt;
  logic cycle_overflow_flag_r;
  logic cycle_overflow_flag_nxt;
  logic tick;
  logic ovf_ev;
  logic match_ev;
  logic pwm_mode;
  pca8_byte_t cnt_inc;
  pca8_byte_t cpl_eff;

  // counter clock is the system clock divided down
  assign tick = counter_run && (div_r == `PCA8_DIV_LAST);
  assign cnt_inc = cnt_r + `PCA8_CNT_ONE;
  assign ovf_ev = tick && (cnt_r == `PCA8_CNT_MAX);
  assign pwm_mode = ecom_r && pwm_select
    && (cycle_length_select == PCA8_CLS_8); // RL4
  // on overflow the reloaded value is compared already,
  // so a compare high of zero keeps the pin high
  assign cpl_eff = ovf_ev ? cph_r : cpl_r; // RL9
  assign match_ev = tick && pwm_mode
    && (cnt_inc == cpl_eff); // RL1 RL10

  always_comb
  begin
    div_nxt = div_r;
    cnt_nxt = cnt_r;
    if (counter_run)
    begin
      if (tick)
      begin
        div_nxt = `PCA8_DIV_RST;
        cnt_nxt = cnt_inc;
      end
      else
      begin
        div_nxt = div_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r <= `PCA8_DIV_RST;
      cnt_r <= `PCA8_CNT_RST;
    end
    else
    begin
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // a software write to the low byte beats the reload
  always_comb
  begin
    cpl_nxt = cpl_r;
    cph_nxt = cph_r;
    ecom_nxt = ecom_r;
    if (ovf_ev)
    begin
      cpl_nxt = cph_r; // RL3
    end
    if (cpl_wr)
    begin
      cpl_nxt = wr_data;
      ecom_nxt = 1'b0; // RL7
    end
    if (cph_wr)
    begin
      cph_nxt = wr_data;
      ecom_nxt = 1'b1; // RL8
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cpl_r <= `PCA8_CMP_RST;
      cph_r <= `PCA8_CMP_RST;
      ecom_r <= 1'b0;
    end
    else
    begin
      cpl_r <= cpl_nxt;
      cph_r <= cph_nxt;
      ecom_r <= ecom_nxt;
    end
  end

  // set wins over a clear in the same cycle
  always_comb
  begin
    pin_nxt = pin_r;
    ccf_nxt = ccf_r;
    cycle_overflow_flag_nxt = cycle_overflow_flag_r;
    if (!pwm_mode)
    begin
      pin_nxt = 1'b0;
    end
    else if (match_ev)
    begin
      pin_nxt = 1'b1; // RL1
    end
    else if (ovf_ev)
    begin
      pin_nxt = 1'b0; // RL2
    end
    if (match_flag_clr)
    begin
      ccf_nxt = 1'b0;
    end
    if (match_ev && match_flag_enable)
    begin
      ccf_nxt = 1'b1; // RL5 RL12
    end
    if (ovf_flag_clr)
    begin
      cycle_overflow_flag_nxt = 1'b0;
    end
    if (ovf_ev)
    begin
      cycle_overflow_flag_nxt = 1'b1; // RL6 RL12
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_r <= 1'b0;
      ccf_r <= 1'b0;
      cycle_overflow_flag_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      ccf_r <= ccf_nxt;
      cycle_overflow_flag_r <= cycle_overflow_flag_nxt;
    end
  end

  assign comparator_enable = ecom_r;
  assign compare_low_byte = cpl_r;
  assign compare_high_byte = cph_r;
  assign counter_low_byte = cnt_r;
  assign module_output_pin = pin_r;
  assign module_match_flag = ccf_r;
  assign cycle_overflow_flag = cycle_overflow_flag_r;

  // helper: counter clocks since the last overflow
  logic [8:0] per_r;
  logic seen_r;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      per_r <= `PCA8_PER_RST;
      seen_r <= 1'b0;
    end
    else if (ovf_ev)
    begin
      per_r <= `PCA8_PER_ONE;
      seen_r <= 1'b1;
    end
    else if (tick)
    begin
      per_r <= per_r + `PCA8_PER_ONE;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_match_set;
    match_ev |=> module_output_pin;
  endproperty
  a_match_set: assert property (p_match_set) // RL1
    else $error("pin not set on match");

  property p_ovf_clr;
    ovf_ev && !match_ev |=> !module_output_pin;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) // RL2
    else $error("pin not cleared on overflow");

  property p_reload;
    ovf_ev && !cpl_wr |=>
      compare_low_byte == $past(compare_high_byte);
  endproperty
  a_reload: assert property (p_reload) // RL3
    else $error("compare low not reloaded");

  property p_mode_off;
    !pwm_mode |=> !module_output_pin;
  endproperty
  a_mode_off: assert property (p_mode_off) // RL4
    else $error("pin high outside pwm mode");

  property p_ccf;
    match_ev && match_flag_enable |=> module_match_flag;
  endproperty
  a_ccf: assert property (p_ccf) // RL5
    else $error("match flag not set");

  property p_ccf_only;
    $rose(module_match_flag) |->
      $past(match_ev && match_flag_enable);
  endproperty
  a_ccf_only: assert property (p_ccf_only) // RL5
    else $error("match flag set without match");

  property p_cycle_overflow_flag;
    ovf_ev |=> cycle_overflow_flag;
  endproperty
  a_cycle_overflow_flag: assert property (p_cycle_overflow_flag) // RL6
    else $error("overflow flag not set");

  property p_period;
    ovf_ev && seen_r |-> per_r == `PCA8_PERIOD;
  endproperty
  a_period: assert property (p_period) // RL6
    else $error("overflow period not 256 counts");

  property p_low_wr;
    cpl_wr && !cph_wr |=> !comparator_enable;
  endproperty
  a_low_wr: assert property (p_low_wr) // RL7
    else $error("enable not cleared by low write");

  property p_high_wr;
    cph_wr |=> comparator_enable;
  endproperty
  a_high_wr: assert property (p_high_wr) // RL8
    else $error("enable not set by high write");

  property p_full_duty;
    ovf_ev && pwm_mode && compare_high_byte == `PCA8_CMP_RST
      |=> module_output_pin;
  endproperty
  a_full_duty: assert property (p_full_duty) // RL9
    else $error("zero compare high not full duty");

  property p_zero_duty;
    !comparator_enable |=> !$rose(module_output_pin);
  endproperty
  a_zero_duty: assert property (p_zero_duty) // RL10
    else $error("pin rose with comparator off");

  property p_sticky;
    module_match_flag && !match_flag_clr |=> module_match_flag;
  endproperty
  a_sticky: assert property (p_sticky) // RL12
    else $error("match flag dropped by itself");

  property p_sticky_ovf;
    cycle_overflow_flag && !ovf_flag_clr
      |=> cycle_overflow_flag;
  endproperty
  a_sticky_ovf: assert property (p_sticky_ovf) // RL12
    else $error("overflow flag dropped by itself");

  property p_cv_match;
    match_ev ##1 module_match_flag;
  endproperty
  c_match: cover property (p_cv_match);

  property p_cv_cycle;
    $rose(module_output_pin) ##[1:1000] $fell(module_output_pin);
  endproperty
  c_cycle: cover property (p_cv_cycle);

  property p_cv_full;
    ovf_ev && pwm_mode && compare_high_byte == `PCA8_CMP_RST;
  endproperty
  c_full: cover property (p_cv_full);

  property p_cv_clr_race;
    ovf_ev && ovf_flag_clr;
  endproperty
  c_clr_race: cover property (p_cv_clr_race);

endmodule : pca8_pwm

// ===== pca8_pwm_bench.sv
// self-checking testbench of the 8-bit pwm counter array module
`timescale 1ns/10ps
module pca8_pwm_bench;
  import pca8_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic counter_run = 1'b0;
  logic cpl_wr = 1'b0;
  logic cph_wr = 1'b0;
  pca8_byte_t wr_data = 8'h00;
  logic pwm_select = 1'b0;
  logic match_flag_enable = 1'b0;
  pca8_cls_e cycle_length_select = PCA8_CLS_8;
  logic match_flag_clr = 1'b0;
  logic ovf_flag_clr = 1'b0;
  logic comparator_enable;
  pca8_byte_t compare_low_byte;
  pca8_byte_t compare_high_byte;
  pca8_byte_t counter_low_byte;
  logic module_output_pin;
  logic module_match_flag;
  logic cycle_overflow_flag;
  int err_total = 0;
  int num_checks = 0;
  int hi_cnt;

  always #50 clk_sys = ~clk_sys;

  pca8_pwm dut_u
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .counter_run(counter_run),
    .cpl_wr(cpl_wr),
    .cph_wr(cph_wr),
    .wr_data(wr_data),
    .pwm_select(pwm_select),
    .match_flag_enable(match_flag_enable),
    .cycle_length_select(cycle_length_select),
    .match_flag_clr(match_flag_clr),
    .ovf_flag_clr(ovf_flag_clr),
    .comparator_enable(comparator_enable),
    .compare_low_byte(compare_low_byte),
    .compare_high_byte(compare_high_byte),
    .counter_low_byte(counter_low_byte),
    .module_output_pin(module_output_pin),
    .module_match_flag(module_match_flag),
    .cycle_overflow_flag(cycle_overflow_flag)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // pin is sampled at negedge so register updates have settled
  task automatic count_hi(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      if (module_output_pin === 1'b1)
        hi_cnt++;
    end
  endtask : count_hi

  // idle cycle at the end so back-to-back writes see the strobe fall
  task automatic wr(input logic hi, input pca8_byte_t d);
    wr_data = d;
    cph_wr = hi;
    cpl_wr = ~hi;
    cyc(1);
    cph_wr = 1'b0;
    cpl_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic clr_flags();
    ovf_flag_clr = 1'b1;
    match_flag_clr = 1'b1;
    cyc(1);
    ovf_flag_clr = 1'b0;
    match_flag_clr = 1'b0;
  endtask : clr_flags

  // one period is 256 ticks of 4 clocks; the bound leaves some slack
  task automatic wait_ovf();
    int i;
    for (i = 0; i < 1100 && cycle_overflow_flag !== 1'b1; i++)
      cyc(1);
    if (cycle_overflow_flag !== 1'b1)
    begin
      err_total++;
      $display("Error at %0t: overflow flag never rose", $time);
      test_done();
    end
  endtask : wait_ovf

  task automatic t_reset();
    chk({comparator_enable, module_output_pin, module_match_flag, cycle_overflow_flag}, 16'h0, "flags at reset");
    chk({compare_low_byte, compare_high_byte}, 16'h0, "compare at reset");
    chk(counter_low_byte, 16'h0, "counter at reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(1'b1, 8'h40);
    chk({comparator_enable, compare_high_byte}, 16'h140, "high write");
    wr(1'b0, 8'h12);
    chk({comparator_enable, compare_low_byte}, 16'h012, "low write");
    wr(1'b1, 8'h40);
    chk(comparator_enable, 1'b1, "low then high");
    $display("test regs done");
  endtask : t_regs

  task automatic t_duty(input pca8_byte_t d, input logic mfe);
    match_flag_enable = mfe;
    pwm_select = 1'b1;
    counter_run = 1'b1;
    wr(1'b1, d);
    clr_flags();
    wait_ovf();
    chk(counter_low_byte, 16'h0, "counter after overflow");
    clr_flags();
    hi_cnt = 0;
    count_hi(1010);
    chk(cycle_overflow_flag, 1'b0, "overflow too early");
    count_hi(14);
    chk(cycle_overflow_flag, 1'b1, "overflow missing");
    chk(16'(hi_cnt), 16'((16'h100 - d) * 4), "high time");
    chk(counter_low_byte, 16'h0, "counter after period");
    chk(compare_low_byte, d, "reload");
    chk(module_match_flag, mfe, "match flag");
    $display("test duty %h done", d);
  endtask : t_duty

  // each pass turns the mode off one way; the pin must stay low
  task automatic t_off();
    int i;
    for (i = 0; i < 5; i++)
    begin
      wr(1'b1, 8'h80);
      cycle_length_select = (i < 3) ? pca8_cls_e'(i + 1) : PCA8_CLS_8;
      pwm_select = (i != 3);
      if (i == 4)
        wr(1'b0, 8'h80);
      cyc(2);
      hi_cnt = 0;
      count_hi(1024);
      chk(16'(hi_cnt), 16'h0, "pin with mode off");
    end
    $display("test off done");
  endtask : t_off

  initial
  begin
    cyc(8);
    nrst = 1'b1;
    cyc(1);
    t_reset();
    t_regs();
    t_duty(8'h40, 1'b0);
    t_duty(8'hc0, 1'b1);
    t_duty(8'h00, 1'b0);
    t_off();
    test_done();
  end
endmodule : pca8_pwm_bench
